// [inc/als_pkg.sv]
package als_pkg;
    localparam int CLK_HZ = 100_000_000;
    // Times in milliseconds
    localparam int BASE_MS = 50;
    localparam int TINT_400_MS = 400;
    localparam int TINT_200_MS = 200;
    localparam int TINT_100_MS = 100;
    localparam int CYC_115_MS = 115;
    localparam int CYC_460_MS = 460;
    localparam int TOUT_MIN_MS = 25;
    localparam int TOUT_MAX_MS = 35;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int BASE_CYC = BASE_MS * CYC_PER_MS;
    // Integration periods in base intervals
    localparam int N_400 = TINT_400_MS / BASE_MS;
    localparam int N_200 = TINT_200_MS / BASE_MS;
    localparam int N_100 = TINT_100_MS / BASE_MS;
    // Power-save share of the cycle: 15 ms per 100 ms of integration
    localparam int PSAVE_PER100_MS = CYC_115_MS - TINT_100_MS;
    // Midpoint of the stuck-bus window, 30 ms
    localparam int TOUT_MS = (TOUT_MIN_MS + TOUT_MAX_MS) / 2;
    localparam int TOUT_CYC = TOUT_MS * CYC_PER_MS;
    localparam logic [1:0] TSEL_400 = 2'h0;
    localparam logic [1:0] TSEL_200 = 2'h1;
    localparam logic [1:0] TSEL_100 = 2'h2;
    localparam logic [1:0] MODE_DOWN = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h2;
    localparam logic [1:0] MODE_NORMAL = 2'h3;
    localparam int CFG_TSEL_LSB = 0;
    localparam int CFG_SKIP_BIT = 3;
    localparam logic [7:0] REG_LOW = 8'h04;
    localparam logic [7:0] REG_HIGH = 8'h05;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    typedef enum logic [1:0] {ALS_IDLE, ALS_INTEG, ALS_PSAVE} als_state_t;
endpackage

// [rtl/als_stuck_det.sv]
module als_stuck_det #(
    parameter int TOUT_CYC = als_pkg::TOUT_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic stuck
);
    localparam int W = $clog2(TOUT_CYC + 1);
    logic [1:0] scl_s_r;
    logic [1:0] sda_s_r;
    logic [W-1:0] cnt_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_in};
            sda_s_r <= {sda_s_r[0], sda_in};
        end
    end

    // Either line low counts toward the timeout
    always_ff @(posedge mclk) begin
        if (!rst_n || (scl_s_r[1] && sda_s_r[1])) begin
            cnt_r <= '0;
            stuck <= 1'b0;
        end else if (cnt_r == W'(TOUT_CYC)) begin
            stuck <= 1'b1;
        end else begin
            cnt_r <= cnt_r + W'(1);
        end
    end
endmodule

// [rtl/als_seq.sv]
// What this block does
// - Integration code 00 gives 400 ms, 01 gives 200 ms, 10 gives 100 ms.
// - Every integration period is a whole number of 50 ms base intervals.
// - Power-save adds a rest making cycles 115 ms, 230 ms or 460 ms.
// - Skip bit set removes the rest; cycle equals integration time.
// - Each finished conversion is moved into the readable data bytes.
// - Result update is double-buffered; a host reading the low byte then the high byte never sees mixed bytes.
// - After transfer, mode picks next integration or power-down.
// - Single mode does one acquisition then powers down.
// - Result is an unsigned 16-bit count saturating at 65535.
// - A bus line held low 25 to 35 ms flags a stuck bus.
// - Low byte read at offset 0x04, high byte at 0x05, read-only.
// - Configuration bits 1:0 select integration, bit 3 skips power-save.
module als_seq #(
    parameter int BASE_CYC = als_pkg::BASE_CYC,
    parameter int TOUT_CYC = als_pkg::TOUT_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire logic [7:0] config_reg,
    input wire logic photo_pulse,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic [15:0] light_count,
    output logic data_valid,
    output logic busy,
    output logic powered_down,
    output logic bus_stuck
);
    localparam int BW = $clog2(BASE_CYC + 1);
    // Power-save rest: 15 ms per 100 ms, scaled from the base interval so it tracks BASE_CYC
    localparam int PS100_CYC = BASE_CYC * als_pkg::PSAVE_PER100_MS / als_pkg::BASE_MS;

    als_pkg::als_state_t state_r;
    logic [1:0] tsel;
    logic skip;
    logic [1:0] pd_s_r;
    logic pd_d_r;
    logic [BW-1:0] base_cnt_r;
    logic [3:0] base_num_r;
    logic [3:0] base_tgt;
    logic [31:0] ps_cnt_r;
    logic [31:0] ps_tgt;
    logic [15:0] acc_r;
    logic [7:0] high_shadow_r;
    logic single_done_r;
    logic base_tick;
    logic integ_end;
    logic stuck_w;

    assign tsel = config_reg[als_pkg::CFG_TSEL_LSB +: 2];
    assign skip = config_reg[als_pkg::CFG_SKIP_BIT];

    // Code 11 falls to the 400 ms length
    always_comb begin
        case (tsel)
            als_pkg::TSEL_200: base_tgt = 4'(als_pkg::N_200);
            als_pkg::TSEL_100: base_tgt = 4'(als_pkg::N_100);
            default: base_tgt = 4'(als_pkg::N_400);
        endcase
        ps_tgt = 32'(PS100_CYC) * 32'(base_tgt) / 32'(als_pkg::N_100);
    end

    // Photodiode pulses come from the analog domain
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pd_s_r <= 2'h0;
            pd_d_r <= 1'b0;
        end else begin
            pd_s_r <= {pd_s_r[0], photo_pulse};
            pd_d_r <= pd_s_r[1];
        end
    end

    // Integration timed as whole 50 ms base intervals
    assign base_tick = (state_r == als_pkg::ALS_INTEG) &&
                       (base_cnt_r == BW'(BASE_CYC - 1));
    assign integ_end = base_tick && (base_num_r == base_tgt - 4'h1);

    always_ff @(posedge mclk) begin
        if (!rst_n || state_r != als_pkg::ALS_INTEG || integ_end) begin
            // Back-to-back integrations must restart the interval count
            base_cnt_r <= '0;
            base_num_r <= 4'h0;
        end else if (base_tick) begin
            base_cnt_r <= '0;
            base_num_r <= base_num_r + 4'h1;
        end else begin
            base_cnt_r <= base_cnt_r + BW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || state_r != als_pkg::ALS_PSAVE) begin
            ps_cnt_r <= 32'h0;
        end else begin
            ps_cnt_r <= ps_cnt_r + 32'h1;
        end
    end

    // Accumulator saturates rather than wrapping
    always_ff @(posedge mclk) begin
        if (!rst_n || state_r != als_pkg::ALS_INTEG || integ_end) begin
            acc_r <= 16'h0;
        end else if (pd_s_r[1] && !pd_d_r && acc_r != als_pkg::COUNT_MAX) begin
            acc_r <= acc_r + 16'h1;
        end
    end

    // Sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= als_pkg::ALS_IDLE;
            single_done_r <= 1'b0;
        end else begin
            case (state_r)
                als_pkg::ALS_IDLE: begin
                    if (mode != als_pkg::MODE_NORMAL && mode != als_pkg::MODE_SINGLE) begin
                        single_done_r <= 1'b0;
                    end
                    if (mode == als_pkg::MODE_NORMAL ||
                        (mode == als_pkg::MODE_SINGLE && !single_done_r)) begin
                        state_r <= als_pkg::ALS_INTEG;
                    end
                end
                als_pkg::ALS_INTEG: begin
                    if (mode != als_pkg::MODE_NORMAL && mode != als_pkg::MODE_SINGLE) begin
                        state_r <= als_pkg::ALS_IDLE;
                    end else if (integ_end) begin
                        if (mode == als_pkg::MODE_SINGLE) begin
                            single_done_r <= 1'b1;
                            state_r <= als_pkg::ALS_IDLE;
                        end else if (skip) begin
                            state_r <= als_pkg::ALS_INTEG;
                        end else begin
                            state_r <= als_pkg::ALS_PSAVE;
                        end
                    end
                end
                als_pkg::ALS_PSAVE: begin
                    if (mode != als_pkg::MODE_NORMAL) begin
                        state_r <= als_pkg::ALS_IDLE;
                    end else if (ps_cnt_r >= ps_tgt - 32'h1) begin
                        state_r <= als_pkg::ALS_INTEG;
                    end
                end
                default: state_r <= als_pkg::ALS_IDLE;
            endcase
        end
    end

    // Result transfer; high byte is snapshotted when low byte is read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            light_count <= 16'h0;
            data_valid <= 1'b0;
        end else begin
            data_valid <= integ_end;
            if (integ_end) begin
                light_count <= acc_r;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data <= 8'h0;
            high_shadow_r <= 8'h0;
        end else if (rd_en) begin
            if (rd_addr == als_pkg::REG_LOW) begin
                rd_data <= light_count[7:0];
                high_shadow_r <= light_count[15:8];
            end else if (rd_addr == als_pkg::REG_HIGH) begin
                rd_data <= high_shadow_r;
            end else begin
                rd_data <= 8'h0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            powered_down <= 1'b1;
            bus_stuck <= 1'b0;
        end else begin
            busy <= (state_r == als_pkg::ALS_INTEG);
            powered_down <= (state_r == als_pkg::ALS_IDLE);
            bus_stuck <= stuck_w;
        end
    end

    als_stuck_det #(.TOUT_CYC(TOUT_CYC)) u_stuck (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .stuck(stuck_w)
    );
endmodule

// [dv/als_seq_properties.sv]
module als_seq_chk #(
    parameter int TOUT_CYC = 50
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic [15:0] light_count,
    input wire logic data_valid,
    input wire logic busy,
    input wire logic powered_down,
    input wire logic bus_stuck
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Raw low time; the input synchroniser adds a few cycles of slack
    int low_r;
    always_ff @(posedge mclk) begin
        if (!rst_n || (scl_in && sda_in)) begin
            low_r <= 0;
        end else begin
            low_r <= low_r + 1;
        end
    end
    a_valid_pulse: assert property (data_valid |=> !data_valid)
        else $error("result pulse too long");
    a_valid_end: assert property (data_valid |-> $past(busy))
        else $error("result without integration");
    a_down_idle: assert property ((mode == als_pkg::MODE_DOWN)[*3] |-> powered_down && !busy)
        else $error("not idle in power-down");
    a_single_stop: assert property (mode == als_pkg::MODE_SINGLE && data_valid ##1
        (mode == als_pkg::MODE_SINGLE)[*3] |-> !busy && powered_down)
        else $error("single mode kept running");
    a_rd_other: assert property (rd_en && rd_addr != 8'h04 && rd_addr != 8'h05 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_rd_low: assert property (rd_en && rd_addr == 8'h04 |=> rd_data == $past(light_count[7:0]))
        else $error("low byte wrong");
    a_rd_pair: assert property (rd_en && rd_addr == 8'h04 ##2 rd_en && rd_addr == 8'h05
        |=> rd_data == $past(light_count[15:8], 3))
        else $error("high byte not from snapshot");
    a_stuck_rise: assert property ($rose(bus_stuck) |-> low_r >= TOUT_CYC * 4 / 5 && low_r <= TOUT_CYC + 8)
        else $error("stuck flag at wrong time");
    a_stuck_long: assert property (low_r > TOUT_CYC + 8 |-> bus_stuck)
        else $error("stuck bus missed");
    a_stuck_clear: assert property ((scl_in && sda_in)[*6] |-> !bus_stuck)
        else $error("stuck flag not cleared");
endmodule
bind als_seq als_seq_chk #(.TOUT_CYC(TOUT_CYC)) u_als_seq_chk (
    .mclk(mclk), .rst_n(rst_n), .mode(mode), .scl_in(scl_in), .sda_in(sda_in), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .light_count(light_count), .data_valid(data_valid),
    .busy(busy), .powered_down(powered_down), .bus_stuck(bus_stuck)
);

// [dv/als_host.sv]
module als_host (
    input wire logic mclk,
    input wire logic [7:0] rd_data,
    output logic rd_en,
    output logic [7:0] rd_addr,
    output logic scl_in,
    output logic sda_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rd_en = 1'h0;
        rd_addr = 8'h00;
        scl_in = 1'h1;
        sda_in = 1'h1;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) #1;
        rd_en = 1'h1;
        rd_addr = a;
        @(posedge mclk) #1;
        d = rd_data;
        rd_en = 1'h0;
        // Address no longer qualified, so it shows its inverse
        rd_addr = ~a;
    endtask
    // Low byte first: it freezes the matching high byte
    task automatic rd_count(output logic [15:0] v);
        logic [7:0] lo, hi;
        rd(8'h04, lo);
        rd(8'h05, hi);
        v = {hi, lo};
    endtask
    // Lux per count for each integration code; the undocumented code is kept at 400 ms
    function automatic int lux_scale_factor(input logic [1:0] t);
        case (t)
            2'h1: return 2;
            2'h2: return 4;
            default: return 1;
        endcase
    endfunction
    task automatic hold_low(input logic on_scl, input int n);
        {scl_in, sda_in} = on_scl ? 2'h1 : 2'h2;
        repeat (n) @(posedge mclk);
        #1 {scl_in, sda_in} = 2'h3;
    endtask
endmodule

// [dv/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BC = 20;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic [1:0] mode = 2'h0;
    logic [7:0] config_reg = 8'h00;
    logic photo_pulse = 1'h0;
    logic scl_in, sda_in, rd_en, data_valid, busy, powered_down, bus_stuck;
    logic [7:0] rd_addr, rd_data, d;
    logic [15:0] light_count, v;
    logic [31:0] seed = 32'hED9FCDCB;
    int mismatches = 0, n_compared = 0, cyc = 0, edges = 0, gap, n, skp, per;
    int q[$];
    always #5 mclk = ~mclk;
    als_seq #(.BASE_CYC(BC), .TOUT_CYC(50)) u_als_seq (
        .mclk(mclk), .rst_n(rst_n), .mode(mode), .config_reg(config_reg),
        .photo_pulse(photo_pulse), .scl_in(scl_in), .sda_in(sda_in), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .light_count(light_count),
        .data_valid(data_valid), .busy(busy), .powered_down(powered_down),
        .bus_stuck(bus_stuck)
    );
    als_host u_als_host (.mclk(mclk), .rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .scl_in(scl_in), .sda_in(sda_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_valid();
        gap = 0;
        do begin
            @(posedge mclk);
            gap++;
        end while (data_valid !== 1'h1 && gap < 1000);
        #1;
    endtask
    // Reference count: photo rising edges between result pulses
    always @(posedge mclk) begin
        if (data_valid === 1'h1) begin
            q.push_back(edges);
            edges = 0;
        end
        #1;
        seed = lfsr(seed);
        edges += int'(seed[0] && !photo_pulse);
        photo_pulse = seed[0];
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        #1 rst_n = 1'h1;
        for (int c = 0; c < 6; c++) begin
            n = (c % 4 == 1) ? 4 : (c % 4 == 2) ? 2 : 8;
            skp = (c < 4);
            // With the rest, a cycle lasts 115 per 100 of integration
            per = skp ? n * BC : n * BC * als_pkg::CYC_115_MS / als_pkg::TINT_100_MS;
            mode = als_pkg::MODE_DOWN;
            config_reg = 8'(skp * 8 + c % 4);
            repeat (3) @(posedge mclk);
            #1 mode = als_pkg::MODE_NORMAL;
            wait_valid();
            wait_valid();
            chk(gap >= per && gap <= per + 1, gap, per);
            // The model counts across the rest too, so counts are compared only back to back
            if (skp != 0) begin
                chk(light_count + 2 >= q[$] && light_count <= q[$] + 2, light_count, q[$]);
            end
            u_als_host.rd_count(v);
            chk(v === light_count, v, light_count);
            chk(u_als_host.lux_scale_factor(2'(c % 4)) == 8 / n, n, 8 / n);
        end
        // Reserved mode code behaves as power-down and re-arms single mode
        mode = 2'h1;
        repeat (3) @(posedge mclk);
        #1 mode = als_pkg::MODE_SINGLE;
        wait_valid();
        chk(gap <= 8 * BC + 6, gap, 8 * BC);
        q.delete();
        repeat (400) @(posedge mclk);
        #1 chk(q.size() == 0 && powered_down === 1'h1, q.size(), 0);
        u_als_host.rd(8'h07, d);
        chk(d === 8'h00, d, 0);
        u_als_host.hold_low(1'h1, 30);
        chk(bus_stuck === 1'h0, bus_stuck, 0);
        u_als_host.hold_low(1'h0, 70);
        chk(bus_stuck === 1'h1, bus_stuck, 1);
        repeat (8) @(posedge mclk);
        #1 chk(bus_stuck === 1'h0, bus_stuck, 0);
        test_done();
    end
endmodule
